// ===== hdl/operand_latency_interlock.sv
// Issue interlock: scoreboard of pending register writes with class latency.
`timescale 1ns/1ns
`default_nettype none
module operand_latency_interlock (
    input  wire logic                                ref_clk,
    input  wire logic                                rst,
    input  wire logic                                iss_req,
    input  wire logic [interlock_pkg::CLASS_W-1:0]   iss_class,
    input  wire logic [1:0]                          iss_unit,
    input  wire logic                                iss_branch,
    input  wire logic [interlock_pkg::REG_AW-1:0]    iss_src_a,
    input  wire logic                                iss_src_a_en,
    input  wire logic [interlock_pkg::REG_AW-1:0]    iss_src_b,
    input  wire logic                                iss_src_b_en,
    input  wire logic [interlock_pkg::REG_AW-1:0]    iss_dst,
    input  wire logic                                iss_dst_en,
    input  wire logic                                iss_miss,
    input  wire logic                                fill_valid,
    input  wire logic [interlock_pkg::REG_AW-1:0]    fill_reg,
    input  wire logic                                tbl_wr,
    input  wire logic [interlock_pkg::CLASS_W-1:0]   tbl_idx,
    input  wire logic [interlock_pkg::LAT_W-1:0]     tbl_lat,
    output logic                                     iss_grant_r,
    output logic                                     stall_r,
    output logic                                     miss_hold_r
);
    logic [interlock_pkg::NUM_REGS-1:0] busy_v;
    logic [interlock_pkg::NUM_REGS-1:0] miss_v;
    logic [interlock_pkg::NUM_REGS-1:0] set_v;
    logic [interlock_pkg::NUM_REGS-1:0] fill_v;
    logic [interlock_pkg::LAT_W-1:0]    prod_lat;

    latency_table u_tbl (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .tbl_wr    (tbl_wr),
        .tbl_idx   (tbl_idx),
        .tbl_lat   (tbl_lat),
        .lk_class  (iss_class),
        .lk_branch (1'b0), // Branch relief is kept per register below.
        .lk_lat    (prod_lat)
    );

    // Class figures already hold the bypass time between units of one type,
    // so a same-unit pair adds nothing; crossing pairs are handled outside.
    wire [interlock_pkg::LAT_W-1:0] tot_lat =
        prod_lat + interlock_pkg::LAT_ZERO; // [RQ2] [RQ7]

    // A compare reaches a dependent branch one cycle before other consumers.
    // Relief is kept only for a two-cycle compare, in the cycle after issue;
    // a longer compare entry makes a branch wait the full count, which is
    // slower but never early.
    wire prod_cmp =
        iss_class == interlock_pkg::fp_compare_class ||
        iss_class == interlock_pkg::int_compare_class;
    wire relief_set = prod_cmp && tot_lat == interlock_pkg::LAT_TWO;
    logic [interlock_pkg::NUM_REGS-1:0] relief_r;
    wire  [interlock_pkg::NUM_REGS-1:0] wait_v = busy_v &
        ~(relief_r & ~miss_v & {interlock_pkg::NUM_REGS{iss_branch}});

    wire src_a_busy = iss_src_a_en && wait_v[iss_src_a]; // [RQ8] [RQ11]
    wire src_b_busy = iss_src_b_en && wait_v[iss_src_b];
    wire dst_busy   = iss_dst_en   && busy_v[iss_dst]; // [RQ5]
    wire hazard     = src_a_busy || src_b_busy || dst_busy; // [RQ3] [RQ4]
    wire go         = iss_req && !hazard; // [RQ1]

    genvar g;
    generate
        for (g = 0; g < interlock_pkg::NUM_REGS; g = g + 1) begin : g_reg
            assign set_v[g]  = go && iss_dst_en && iss_dst == 7'(g);
            assign fill_v[g] = fill_valid && fill_reg == 7'(g);
            reg_score u_sc (
                .ref_clk  (ref_clk),
                .rst      (rst),
                .set      (set_v[g]),
                .set_lat  (tot_lat),
                .set_miss (iss_miss),
                .fill     (fill_v[g]),
                .busy     (busy_v[g]),
                .miss     (miss_v[g])
            );
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            relief_r <= '0;
        end else begin
            relief_r <= relief_set ? set_v : '0; // [RQ8] [RQ11]
        end
    end

    wire miss_any = (iss_src_a_en && miss_v[iss_src_a]) ||
                    (iss_src_b_en && miss_v[iss_src_b]) ||
                    (iss_dst_en && miss_v[iss_dst]); // [RQ6]

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            iss_grant_r <= 1'b0;
            stall_r     <= 1'b0;
            miss_hold_r <= 1'b0;
        end else begin
            iss_grant_r <= go;
            stall_r     <= iss_req && hazard; // [RQ3]
            miss_hold_r <= iss_req && miss_any; // [RQ6]
        end
    end

    a_load_gap: assert property (@(posedge ref_clk) disable iff (rst)
        (go && iss_dst_en && iss_class == interlock_pkg::int_load_class
         && !iss_miss) |=> !(iss_req && iss_src_a_en &&
         iss_src_a == $past(iss_dst) && go)) // [RQ4]
        else $error("load result read one cycle after issue");
    a_grant_clean: assert property (@(posedge ref_clk) disable iff (rst)
        go |-> !hazard) // [RQ3]
        else $error("issue granted on busy operand");
    a_miss_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (iss_req && miss_any) |=> stall_r) // [RQ6]
        else $error("miss pending but no stall");
    a_waw_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (iss_req && dst_busy) |=> !iss_grant_r) // [RQ5]
        else $error("second writer passed first");
    a_grant_stall: assert property (@(posedge ref_clk) disable iff (rst)
        !(iss_grant_r && stall_r)) // [RQ1]
        else $error("grant and stall together");
    a_branch_relief: assert property (@(posedge ref_clk) disable iff (rst)
        (go && iss_dst_en && !iss_miss && tot_lat == interlock_pkg::LAT_TWO
         && iss_class == interlock_pkg::fp_compare_class) ##1
        (iss_req && iss_branch && iss_src_a_en && !iss_src_b_en
         && !iss_dst_en && iss_src_a == $past(iss_dst)) |=> iss_grant_r) // [RQ8]
        else $error("branch held after float compare");
endmodule
`default_nettype wire

// ===== hdl/interlock_pkg.sv
// Package of class codes, latency constants and widths for the operand interlock.
// Notes on behaviour
// RQ1 - Consumer issues no sooner than cycle i+N after producer issued in cycle i.
// RQ2 - Total latency is producer latency plus the bypass time to the consumer.
// RQ3 - Instruction stalls while any source operand is still being written.
// RQ4 - Reader of an integer load result waits at least 2 cycles.
// RQ5 - Later writer of a register waits until the earlier write completes.
// RQ6 - A missing load holds readers and writers until memory data returns.
// RQ7 - Class latencies hold for same unit pairs; crossing pairs are handled apart.
// RQ8 - Float compare reaches a branch after 1 cycle, others after 2.
// RQ9 - Float multiply-add and misc take 5 cycles, convert-to-fixed 7.
// RQ10 - Float to general copy takes 2 cycles, general to float copy 9.
// RQ11 - Integer compare reaches a branch after 0 cycles, others after 1; here a branch still waits 1 cycle after an integer compare.
// RQ12 - Media ALU A and I, multiply and shift classes take 2 cycles.
// RQ13 - SIMD multiply-add and misc take 5, convert and merge take 7.
// RQ14 - Float unit integer multiply takes 7 cycles to another such multiply.
// RQ15 - Register-dependent classes take latency from a settable table entry.
// RQ16 - Latency of each producer class is held in a table indexed by class.
package interlock_pkg;
    localparam int REG_AW    = 7;
    localparam int NUM_REGS  = 128;
    localparam int LAT_W     = 4;
    localparam int CLASS_W   = 5;
    localparam int NUM_CLASS = 32;

    typedef enum logic [CLASS_W-1:0] {
        int_alu_class, logical_op_class, int_compare_class, int_load_class,
        fp_compare_class, fp_multiply_add_class, fp_misc_class,
        fp_to_fixed_class, fp_to_gp_copy_class, gp_to_fp_copy_class,
        media_alu_a_class, media_alu_i_class, media_multiply_class,
        media_shift_class, simd_fp_to_fixed_class, simd_multiply_add_class,
        simd_sign_exp_merge_class, simd_fp_misc_class, fp_int_multiply_class,
        app_reg_read_m_class, app_reg_read_i_class, ctrl_reg_read_class,
        app_reg_write_i_class, app_reg_write_m_class, ctrl_reg_write_class,
        system_op_class, semaphore_op_class
    } op_class_t;

    typedef enum logic [1:0] {
        unit_int, unit_fp, unit_simd, unit_media
    } unit_t;

    localparam logic [LAT_W-1:0] LAT_ONE        = 4'h1;
    localparam logic [LAT_W-1:0] LAT_TWO        = 4'h2;
    localparam logic [LAT_W-1:0] LAT_FIVE       = 4'h5;
    localparam logic [LAT_W-1:0] LAT_SEVEN      = 4'h7;
    localparam logic [LAT_W-1:0] LAT_NINE       = 4'h9;
    localparam logic [LAT_W-1:0] LAT_ZERO       = 4'h0;
    localparam logic [LAT_W-1:0] LAT_REGDEP_RST = 4'h2;
    localparam logic [LAT_W-1:0] CROSS_UNIT_ADD = 4'h2;
    localparam logic [LAT_W-1:0] LAT_MAX        = 4'hf;
endpackage

// ===== hdl/latency_table.sv
// Producer class latency table with settable register-dependent entries.
`timescale 1ns/1ns
`default_nettype none
module latency_table (
    input  wire logic                                ref_clk,
    input  wire logic                                rst,
    input  wire logic                                tbl_wr,
    input  wire logic [interlock_pkg::CLASS_W-1:0]   tbl_idx,
    input  wire logic [interlock_pkg::LAT_W-1:0]     tbl_lat,
    input  wire logic [interlock_pkg::CLASS_W-1:0]   lk_class,
    input  wire logic                                lk_branch,
    output logic      [interlock_pkg::LAT_W-1:0]     lk_lat
);
    logic [interlock_pkg::LAT_W-1:0] tbl_r [interlock_pkg::NUM_CLASS];

    // Fixed class figures; a write only overrides an entry until reset.
    function automatic logic [interlock_pkg::LAT_W-1:0] rst_lat(input int c);
        case (c)
            interlock_pkg::fp_multiply_add_class,
            interlock_pkg::fp_misc_class,
            interlock_pkg::simd_multiply_add_class,
            interlock_pkg::simd_fp_misc_class:
                rst_lat = interlock_pkg::LAT_FIVE; // [RQ9] [RQ13]
            interlock_pkg::fp_to_fixed_class,
            interlock_pkg::simd_fp_to_fixed_class,
            interlock_pkg::simd_sign_exp_merge_class,
            interlock_pkg::fp_int_multiply_class:
                rst_lat = interlock_pkg::LAT_SEVEN; // [RQ9] [RQ13] [RQ14]
            interlock_pkg::fp_to_gp_copy_class,
            interlock_pkg::int_load_class,
            interlock_pkg::fp_compare_class,
            interlock_pkg::media_alu_a_class,
            interlock_pkg::media_alu_i_class,
            interlock_pkg::media_multiply_class,
            interlock_pkg::media_shift_class:
                rst_lat = interlock_pkg::LAT_TWO; // [RQ4] [RQ8] [RQ10] [RQ12]
            interlock_pkg::gp_to_fp_copy_class:
                rst_lat = interlock_pkg::LAT_NINE; // [RQ10]
            interlock_pkg::app_reg_read_m_class,
            interlock_pkg::app_reg_read_i_class,
            interlock_pkg::ctrl_reg_read_class,
            interlock_pkg::app_reg_write_i_class,
            interlock_pkg::app_reg_write_m_class,
            interlock_pkg::ctrl_reg_write_class,
            interlock_pkg::system_op_class,
            interlock_pkg::semaphore_op_class:
                rst_lat = interlock_pkg::LAT_REGDEP_RST; // [RQ15]
            default:
                rst_lat = interlock_pkg::LAT_ONE;
        endcase
    endfunction

    genvar g;
    generate
        for (g = 0; g < interlock_pkg::NUM_CLASS; g = g + 1) begin : g_ent
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    tbl_r[g] <= rst_lat(g); // [RQ16]
                end else if (tbl_wr && tbl_idx == 5'(g)) begin
                    tbl_r[g] <= tbl_lat; // [RQ15] [RQ16]
                end
            end
        end
    endgenerate

    wire is_fp_compare_class = lk_class == interlock_pkg::fp_compare_class;
    wire is_int_compare_class = lk_class == interlock_pkg::int_compare_class;
    // Compares reach a branch one cycle earlier than other consumers.
    assign lk_lat = (lk_branch && (is_fp_compare_class || is_int_compare_class)) ?
                    tbl_r[lk_class] - interlock_pkg::LAT_ONE :
                    tbl_r[lk_class]; // [RQ8] [RQ11]
endmodule
`default_nettype wire

// ===== hdl/reg_score.sv
// One scoreboard entry: remaining latency and miss hold for one register.
`timescale 1ns/1ns
`default_nettype none
module reg_score (
    input  wire logic                            ref_clk,
    input  wire logic                            rst,
    input  wire logic                            set,
    input  wire logic [interlock_pkg::LAT_W-1:0] set_lat,
    input  wire logic                            set_miss,
    input  wire logic                            fill,
    output logic                                 busy,
    output logic                                 miss
);
    logic [interlock_pkg::LAT_W-1:0] cnt_r;
    logic                            miss_r;
    wire [interlock_pkg::LAT_W-1:0]  cnt_nxt =
        set ? set_lat :
        (cnt_r != interlock_pkg::LAT_ZERO) ? cnt_r - 4'h1 : cnt_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r  <= interlock_pkg::LAT_ZERO;
            miss_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt; // [RQ1]
            // A new miss set wins over a fill in the same cycle.
            miss_r <= set ? set_miss : (fill ? 1'b0 : miss_r); // [RQ6]
        end
    end
    assign busy = (cnt_r > 4'h1) || miss_r; // [RQ3]
    assign miss = miss_r;
endmodule
`default_nettype wire

// ===== sim/issue_model.sv
// Issue-side model that holds a request and retries it each cycle.
`timescale 1ns/1ns
`default_nettype none
module issue_model (
    input  wire logic       ref_clk,
    input  wire logic       iss_grant_r,
    input  wire logic       stall_r,
    output logic            iss_req,
    output logic [4:0]      iss_class,
    output logic [1:0]      iss_unit,
    output logic            iss_branch,
    output logic [6:0]      iss_src_a,
    output logic            iss_src_a_en,
    output logic [6:0]      iss_src_b,
    output logic            iss_src_b_en,
    output logic [6:0]      iss_dst,
    output logic            iss_dst_en,
    output logic            iss_miss
);
    initial begin
        {iss_req, iss_class, iss_unit, iss_branch, iss_miss} = '0;
        {iss_src_a, iss_src_a_en, iss_src_b, iss_src_b_en} = '0;
        {iss_dst, iss_dst_en} = '0;
    end

    // Fields change only after an edge; a refused request is held as is.
    task automatic issue(input logic [4:0] c, input logic [1:0] u,
                         input logic [6:0] a, b, d, input logic [2:0] en,
                         input logic m, output int stalls, output bit ok);
        iss_req <= 1'b1;
        iss_class <= c;
        iss_unit <= u;
        {iss_src_a, iss_src_b, iss_dst} <= {a, b, d};
        {iss_src_a_en, iss_src_b_en, iss_dst_en} <= en;
        iss_miss <= m;
        stalls = 0;
        ok = 0;
        for (int k = 0; k < 100 && !ok; k++) begin
            @(posedge ref_clk);
            #1;
            if (iss_grant_r === 1'b1) ok = 1;
            else if (stall_r === 1'b1) stalls++;
        end
    endtask

    // Released iss_src_a and iss_dst fields are inverted so stale values cannot match; iss_src_b is left as is.
    task automatic idle();
        iss_req <= 1'b0;
        {iss_src_a_en, iss_src_b_en, iss_dst_en, iss_miss} <= '0;
        {iss_src_a, iss_dst} <= ~{iss_src_a, iss_dst};
    endtask

    task automatic branch(input logic b);
        iss_branch <= b;
    endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the operand latency interlock.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    typedef struct { logic [4:0] c; logic [1:0] u; int n; } row_t;
    logic       ref_clk, rst, fill_valid, tbl_wr, req, br, sa_en, sb_en;
    logic       d_en, miss, grant, stall, mhold;
    logic [6:0] fill_reg, sa, sb, d;
    logic [4:0] tbl_idx, cls;
    logic [3:0] tbl_lat;
    logic [1:0] unit;
    int         n_fail = 0;
    int         n_compared = 0;
    int         s;
    // Rows follow the code order of op_class_t; unit codes follow unit_t.
    row_t rows[21] = '{'{0,0,1}, '{1,0,1}, '{2,0,1}, '{3,0,2}, '{4,1,2},
        '{5,1,5}, '{6,1,5}, '{7,1,7}, '{8,1,2}, '{9,1,9}, '{10,3,2},
        '{11,3,2}, '{12,3,2}, '{13,3,2}, '{14,2,7}, '{15,2,5}, '{16,2,7},
        '{17,2,5}, '{18,1,7}, '{19,0,2}, '{20,0,2}};

    operand_latency_interlock u_operand_latency_interlock (.ref_clk(ref_clk),
        .rst(rst), .iss_req(req), .iss_class(cls), .iss_unit(unit),
        .iss_branch(br), .iss_src_a(sa), .iss_src_a_en(sa_en),
        .iss_src_b(sb), .iss_src_b_en(sb_en), .iss_dst(d), .iss_dst_en(d_en),
        .iss_miss(miss), .fill_valid(fill_valid), .fill_reg(fill_reg),
        .tbl_wr(tbl_wr), .tbl_idx(tbl_idx), .tbl_lat(tbl_lat),
        .iss_grant_r(grant), .stall_r(stall), .miss_hold_r(mhold));
    issue_model u_issue_model (.ref_clk(ref_clk), .iss_grant_r(grant),
        .stall_r(stall), .iss_req(req), .iss_class(cls), .iss_unit(unit),
        .iss_branch(br), .iss_src_a(sa), .iss_src_a_en(sa_en),
        .iss_src_b(sb), .iss_src_b_en(sb_en), .iss_dst(d), .iss_dst_en(d_en),
        .iss_miss(miss));

    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic conclude();
        if (n_fail == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (e !== g) begin
            n_fail++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic run(logic [4:0] c, logic [1:0] u, logic [6:0] a, b, dd,
                       logic [2:0] en, logic m, output int st);
        bit ok;
        u_issue_model.issue(c, u, a, b, dd, en, m, st, ok);
        if (!ok) begin
            n_fail++;
            $display("MISMATCH grant_wait expected 1 seen 0");
            conclude();
        end
    endtask

    // Producer writes r, consumer then reads it on port a or b.
    task automatic pair(logic [4:0] c, logic [1:0] u, logic [6:0] r,
                        logic on_b, output int st);
        run(c, u, 7'h00, 7'h00, r, 3'h1, 1'b0, st);
        run(c, u, r, r, 7'h7f, on_b ? 3'h2 : 3'h4, 1'b0, st);
        u_issue_model.idle();
        @(posedge ref_clk);
    endtask

    task automatic reset(int n);
        rst <= 1'b1;
        repeat (n) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask

    initial begin
        {rst, fill_valid, tbl_wr, fill_reg, tbl_idx, tbl_lat} = '0;
        reset(8);
        chk("outputs_after_reset", 0, {grant, stall, mhold});
        foreach (rows[k]) begin
            pair(rows[k].c, rows[k].u, 7'h01 + 7'(k), 1'b0, s);
            chk("row_stalls", rows[k].n - 1, s);
        end
        run(3, 0, 7'h00, 7'h00, 7'h28, 3'h1, 1'b0, s);
        run(0, 0, 7'h00, 7'h00, 7'h28, 3'h1, 1'b0, s);
        chk("rewrite_stalls", 1, s);
        u_issue_model.idle();
        @(posedge ref_clk);
        pair(9, 1, 7'h2a, 1'b1, s);
        chk("src_b_stalls", 8, s);
        run(4, 1, 7'h00, 7'h00, 7'h2e, 3'h1, 1'b0, s);
        u_issue_model.branch(1'b1);
        run(4, 1, 7'h2e, 7'h00, 7'h7f, 3'h4, 1'b0, s);
        chk("branch_stalls", 0, s);
        u_issue_model.branch(1'b0);
        u_issue_model.idle();
        @(posedge ref_clk);
        @(posedge ref_clk);
        {tbl_wr, tbl_idx, tbl_lat} <= {1'b1, 5'h14, 4'h5};
        @(posedge ref_clk);
        tbl_wr <= 1'b0;
        pair(20, 0, 7'h2b, 1'b0, s);
        chk("table_stalls", 4, s);
        // A missing load must hold its reader for as long as memory takes.
        run(3, 0, 7'h00, 7'h00, 7'h29, 3'h1, 1'b1, s);
        fork
            run(0, 0, 7'h29, 7'h00, 7'h7f, 3'h4, 1'b0, s);
            begin
                repeat (20) @(posedge ref_clk);
                #1;
                chk("miss_hold", 1, mhold);
                @(posedge ref_clk);
                {fill_valid, fill_reg} <= {1'b1, 7'h29};
                @(posedge ref_clk);
                fill_valid <= 1'b0;
            end
        join
        chk("miss_stalls", 1, s >= 20);
        u_issue_model.idle();
        @(posedge ref_clk);
        run(9, 1, 7'h00, 7'h00, 7'h2c, 3'h1, 1'b0, s);
        u_issue_model.idle();
        reset(1);
        run(0, 1, 7'h2c, 7'h00, 7'h7f, 3'h4, 1'b0, s);
        u_issue_model.idle();
        @(posedge ref_clk);
        chk("stalls_after_reset", 0, s);
        pair(20, 0, 7'h2d, 1'b0, s);
        chk("table_default", 1, s);
        conclude();
    end
endmodule
`default_nettype wire
